// File: src/acr_readout.sv
// Purpose: Conversion start, chip-select mode detection and serial readout.
// Assumes: Host keeps its own timing duties; sample data arrives on sample_i.
// Notes:   Daisy-chain mode is only detected and reported, not shifted.
module acr_readout
	import acr_pkg::*;
#(
	parameter int unsigned CONV_CYCLES_P = CONV_CYCLES
)
(
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire logic         conv_start_pin_i,
	input  wire logic         serial_in_i,
	input  wire logic         sclk_i,
	input  wire logic         wiring_4_i,
	input  wire logic [15:0]  sample_i,
	output logic              serial_out_o,
	output logic              serial_out_oe_o,
	output logic              converting_o,
	output logic              daisy_mode_o,
	output logic              sample_strobe_o
);
	import acr_pkg::*;

	// ----------------------------------------
	// Pin synchronisation
	// ----------------------------------------
	acr_pins_t pins;
	acr_pins_t cur;
	acr_pins_t prv;

	assign pins = '{conv_start: conv_start_pin_i, serial_in: serial_in_i, sclk: sclk_i};

	acr_sync u_sync (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.pins_i    (pins),
		.sync_o    (cur),
		.prev_o    (prv)
	);

	logic cs_rise;
	logic cs_fall;
	logic sclk_fall;
	logic sel_level;
	logic sel_rise;
	logic sel_fall;

	assign cs_rise   = cur.conv_start & ~prv.conv_start;
	assign cs_fall   = ~cur.conv_start & prv.conv_start;
	assign sclk_fall = ~cur.sclk & prv.sclk;

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef enum logic [1:0] {
		ACR_IDLE,
		ACR_CONVERT,
		ACR_ACQUIRE
	} acr_state_t;

	acr_state_t   state;
	acr_state_t   next_state;
	acr_wiring_t  wiring;
	acr_wiring_t  next_wiring;
	logic         daisy;
	logic         next_daisy;
	logic [15:0]  timer;
	logic [15:0]  next_timer;
	logic [15:0]  shreg;
	logic [15:0]  next_shreg;
	logic [4:0]   edges;
	logic [4:0]   next_edges;
	logic         busy_frame;
	logic         next_busy_frame;
	acr_dout_t    dout;
	acr_dout_t    next_dout;
	logic         strobe;
	logic         next_strobe;

	// In 3-wire mode the start pin is the select; in 4-wire the serial input is.
	assign sel_level = (wiring == ACR_WIRE4) ? cur.serial_in : cur.conv_start;
	assign sel_rise  = (wiring == ACR_WIRE4) ? (cur.serial_in & ~prv.serial_in) : cs_rise;
	assign sel_fall  = (wiring == ACR_WIRE4) ? (~cur.serial_in & prv.serial_in) : cs_fall;

	always_comb begin
		next_state      = state;
		next_wiring     = wiring;
		next_daisy      = daisy;
		next_timer      = timer;
		next_shreg      = shreg;
		next_edges      = edges;
		next_busy_frame = busy_frame;
		next_dout       = dout;
		next_strobe     = 1'b0;
		if (cs_rise) begin
			next_daisy  = ~cur.serial_in;
			next_wiring = wiring_4_i ? ACR_WIRE4 : ACR_WIRE3;
			next_dout   = '{data: 1'b0, enable: 1'b0};
			next_strobe = 1'b1;
			next_state  = ACR_CONVERT;
			next_timer  = 16'h0000;
			next_edges  = 5'h00;
		end else begin
			unique case (state)
				ACR_IDLE: begin
				end
				ACR_CONVERT: begin
					if (timer >= 16'(CONV_CYCLES_P - 1)) begin
						// two's complement word kept as is
						next_shreg = sample_i;
						next_state = ACR_ACQUIRE;
						next_busy_frame = ~sel_level & ~daisy;
						if (~sel_level & ~daisy) begin
							next_dout = '{data: 1'b0, enable: 1'b1};
						end
					end else begin
						next_timer = timer + 16'h0001;
					end
				end
				ACR_ACQUIRE: begin
					if (!daisy) begin
						if (sel_rise) begin
							next_dout = '{data: 1'b0, enable: 1'b0};
						end else if (sel_fall && !busy_frame && edges == 5'h00) begin
							next_dout = '{data: shreg[15], enable: 1'b1};
							next_shreg = {shreg[14:0], 1'b0};
							next_edges = 5'h01;
						end else if (sclk_fall && dout.enable) begin
							if (busy_frame && edges == 5'h00) begin
								// first data bit after busy bit
								next_dout.data = shreg[15];
								next_shreg = {shreg[14:0], 1'b0};
								next_edges = 5'h02;
							end else if (edges == (busy_frame ? LAST_BIT_BUSY
							                                  : LAST_BIT_PLAIN)) begin
								next_dout = '{data: 1'b0, enable: 1'b0};
							end else begin
								next_dout.data = shreg[15];
								next_shreg = {shreg[14:0], 1'b0};
								next_edges = edges + 5'h01;
							end
						end
					end
				end
				default: begin
					next_state = ACR_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state      <= ACR_IDLE;
			wiring     <= ACR_WIRE3;
			daisy      <= 1'b0;
			timer      <= 16'h0000;
			shreg      <= RESULT_RESET;
			edges      <= 5'h00;
			busy_frame <= 1'b0;
			dout       <= '{data: 1'b0, enable: 1'b0};
			strobe     <= 1'b0;
		end else begin
			state      <= next_state;
			wiring     <= next_wiring;
			daisy      <= next_daisy;
			timer      <= next_timer;
			shreg      <= next_shreg;
			edges      <= next_edges;
			busy_frame <= next_busy_frame;
			dout       <= next_dout;
			strobe     <= next_strobe;
		end
	end

	assign serial_out_o    = dout.data;
	assign serial_out_oe_o = dout.enable;
	assign converting_o    = (state == ACR_CONVERT);
	assign daisy_mode_o    = daisy;
	assign sample_strobe_o = strobe;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_start_tristate: assert property (
		@(posedge sys_clk_i) disable iff (rst_i) cs_rise |=> !serial_out_oe_o && converting_o)
		else $error("Output not released or conversion not started.");

	a_mode_select: assert property (
		@(posedge sys_clk_i) disable iff (rst_i) cs_rise |=> daisy_mode_o == !$past(cur.serial_in))
		else $error("Mode not taken from serial input.");

	a_conv_hold: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(converting_o && !cs_rise && timer < 16'(CONV_CYCLES_P - 1)) |=> converting_o)
		else $error("Conversion ended early.");

	a_busy_low: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		($past(converting_o) && !converting_o && busy_frame) |-> serial_out_oe_o && !serial_out_o)
		else $error("Busy bit not driven low.");

	a_msb_out: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(state == ACR_ACQUIRE && !daisy && !busy_frame && sel_fall && edges == 5'h00 && !cs_rise)
		|=> serial_out_oe_o && serial_out_o == $past(shreg[15]))
		else $error("MSB not presented on select fall.");

	a_release_sel: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(state == ACR_ACQUIRE && !daisy && sel_rise) |=> !serial_out_oe_o)
		else $error("Output not released on deselect.");

	a_edge_limit: assert property (
		@(posedge sys_clk_i) disable iff (rst_i) edges <= LAST_BIT_BUSY)
		else $error("Edge count above limit.");

	a_plain_limit: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(!busy_frame && edges == LAST_BIT_PLAIN && sclk_fall && !cs_rise && !sel_rise
		 && state == ACR_ACQUIRE) |=> !serial_out_oe_o)
		else $error("Output not released after last bit.");

	a_shift_bit: assert property (
		@(posedge sys_clk_i) disable iff (rst_i)
		(state == ACR_ACQUIRE && serial_out_oe_o && sclk_fall && !cs_rise && !sel_rise
		 && edges != 5'h00 && edges < LAST_BIT_PLAIN) |=> serial_out_o == $past(shreg[15]))
		else $error("Bit not shifted on SCLK fall.");

	a_daisy_quiet: assert property (
		@(posedge sys_clk_i) disable iff (rst_i) daisy_mode_o |-> !serial_out_oe_o)
		else $error("Output driven in daisy-chain mode.");

endmodule // acr_readout

// File: src/acr_pkg.sv
// Purpose: Shared constants and types for the converter readout block.
// Assumes: System clock of 50 MHz; all pins are asynchronous to it.
// Notes:   Conversion time is a parameter; the 3000 ns figure fixed here is only its default.
package acr_pkg;

	localparam int unsigned  CLK_PERIOD_NS     = 20;
	localparam int unsigned  CONV_TIME_NS      = 3000;
	localparam int unsigned  CONV_CYCLES       = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned  DATA_BITS         = 16;
	localparam logic [4:0]   LAST_BIT_PLAIN    = 5'h10;
	localparam logic [4:0]   LAST_BIT_BUSY     = 5'h11;
	localparam logic [15:0]  RESULT_RESET      = 16'h0000;

	typedef enum logic {
		ACR_WIRE3,
		ACR_WIRE4
	} acr_wiring_t;

	typedef struct packed {
		logic conv_start;
		logic serial_in;
		logic sclk;
	} acr_pins_t;

	typedef struct packed {
		logic data;
		logic enable;
	} acr_dout_t;

endpackage : acr_pkg

// File: src/acr_sync.sv
// Purpose: Two-flop synchroniser for the pin bundle, with a delayed copy for edges.
// Assumes: Inputs are asynchronous to sys_clk_i.
// Notes:   The first stage feeds only the second stage.
module acr_sync
	import acr_pkg::*;
(
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	input  wire acr_pins_t   pins_i,
	output acr_pins_t        sync_o,
	output acr_pins_t        prev_o
);
	acr_pins_t stage1;
	acr_pins_t stage2;
	acr_pins_t stage3;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			stage1 <= '{conv_start: 1'b0, serial_in: 1'b1, sclk: 1'b0};
			stage2 <= '{conv_start: 1'b0, serial_in: 1'b1, sclk: 1'b0};
			stage3 <= '{conv_start: 1'b0, serial_in: 1'b1, sclk: 1'b0};
		end else begin
			stage1 <= pins_i;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	assign sync_o = stage2;
	assign prev_o = stage3;

endmodule // acr_sync

// File: verif/acr_host.sv
// Purpose: Host model that drives the start, select and serial clock pins.
// Assumes: Pins change just after a rising edge of sys_clk_i.
// Notes:   Waits are fixed counts; the maximum conversion time is a parameter.
module acr_host
#(
	parameter int unsigned CONV_WAIT = 20
)
(
	input  wire logic  sys_clk_i,
	input  wire logic  dout_i,
	output logic       conv_start_o,
	output logic       serial_in_o,
	output logic       sclk_o
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		conv_start_o = 1'b0;
		serial_in_o = 1'b1;
		sclk_o = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_i);
	endtask

	task automatic convert(input logic w4, input logic busy);
		conv_start_o <= 1'b1;
		tick(2);
		serial_in_o <= ~(w4 & busy);
		conv_start_o <= ~(~w4 & busy);
		tick(CONV_WAIT);
	endtask

	task automatic select(input logic w4);
		serial_in_o <= ~w4;
		conv_start_o <= w4;
		tick(6);
	endtask

	task automatic shift(output logic b);
		sclk_o <= 1'b1;
		tick(3);
		sclk_o <= 1'b0;
		tick(5);
		b = dout_i;
	endtask

	task automatic deselect();
		serial_in_o <= 1'b1;
		conv_start_o <= 1'b1;
		tick(6);
	endtask

	task automatic daisy_start();
		serial_in_o <= 1'b0;
		tick(2);
		conv_start_o <= 1'b1;
		tick(2);
		serial_in_o <= 1'b1;
		tick(CONV_WAIT);
	endtask

	// Waiting a full conversion lets any start made by a deselect run out.
	task automatic idle();
		conv_start_o <= 1'b0;
		serial_in_o <= 1'b1;
		tick(CONV_WAIT);
	endtask
endmodule // acr_host

// File: verif/adc_chip_select_serial_readout_test.sv
// Purpose: Self-checking bench for the converter readout block.
// Assumes: Conversion shortened to ten clocks through the parameter.
// Notes:   The data line has a pull-up, as the busy variants need.
module adc_chip_select_serial_readout_test;
	timeunit 1ns;
	timeprecision 1ps;
	import acr_pkg::*;

	typedef struct packed {
		logic        w4;
		logic        busy;
		logic [15:0] smp;
	} acr_row_t;

	localparam acr_row_t ROWS [4] = '{
		'{1'b0, 1'b0, 16'h8000}, '{1'b0, 1'b1, 16'h7FFF},
		'{1'b1, 1'b0, 16'hA5C3}, '{1'b1, 1'b1, 16'h0001}};

	logic        sys_clk;
	logic        rst_i;
	logic        wiring;
	logic [15:0] sample;
	logic        strobe;
	int          n_strobe = 0;
	logic        conv_start;
	logic        serial_in;
	logic        sclk;
	logic        dout;
	logic        oe;
	logic        converting;
	logic        daisy;
	wire         line;
	int          fails = 0;
	int          n_tests = 0;
	int          cycles = 0;

	// A released line floats up through the pull-up, never to the last bit.
	assign line = oe ? dout : 1'b1;

	acr_host #(.CONV_WAIT(20)) host (.sys_clk_i(sys_clk), .dout_i(line),
		.conv_start_o(conv_start), .serial_in_o(serial_in), .sclk_o(sclk));

	acr_readout #(.CONV_CYCLES_P(10)) DUT (.sys_clk_i(sys_clk), .rst_i(rst_i),
		.conv_start_pin_i(conv_start), .serial_in_i(serial_in), .sclk_i(sclk),
		.wiring_4_i(wiring), .sample_i(sample), .serial_out_o(dout),
		.serial_out_oe_o(oe), .converting_o(converting), .daisy_mode_o(daisy),
		.sample_strobe_o(strobe));

	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Counting pulses keeps the one-cycle strobe visible to later checks.
	always @(posedge sys_clk) begin
		if (strobe === 1'b1)
			n_strobe++;
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fails++;
			print_verdict();
		end
	end

	task automatic run_row(input acr_row_t r);
		logic [15:0] got;
		logic        b;
		int          n0;
		n0 = n_strobe;
		wiring <= r.w4;
		sample <= r.smp;
		host.tick(2);
		host.convert(r.w4, r.busy);
		check(16'(n_strobe - n0), 16'h0001);
		host.select(r.w4);
		check({15'h0, oe}, 16'h0001);
		got = {15'h0, line};
		if (r.busy)
			check(got, 16'h0000);
		repeat (15 + r.busy) begin
			host.shift(b);
			got = {got[14:0], b};
		end
		check(got, r.smp);
		host.shift(b);
		check({15'h0, oe}, 16'h0000);
		host.idle();
	endtask

	initial begin
		logic b;
		rst_i = 1'b1;
		wiring = 1'b0;
		sample = 16'h0000;
		repeat (6) @(posedge sys_clk);
		rst_i <= 1'b0;
		host.tick(4);
		check({13'h0, oe, converting, daisy}, 16'h0000);
		foreach (ROWS[i])
			run_row(ROWS[i]);
		// An early deselect cuts the word short in both wirings.
		for (int w = 0; w < 2; w++) begin
			wiring <= w[0];
			host.tick(2);
			host.convert(w[0], 1'b0);
			host.select(w[0]);
			repeat (3) host.shift(b);
			host.deselect();
			check({15'h0, oe}, 16'h0000);
			check({15'h0, converting}, {15'h0, ~w[0]});
			host.idle();
		end
		wiring <= 1'b0;
		host.tick(2);
		// A reset in mid-read drops the output at once.
		host.convert(1'b0, 1'b0);
		host.select(1'b0);
		rst_i <= 1'b1;
		host.tick(2);
		check({14'h0, oe, converting}, 16'h0000);
		rst_i <= 1'b0;
		host.idle();
		host.daisy_start();
		check({14'h0, daisy, oe}, 16'h0002);
		host.idle();
		print_verdict();
	end
endmodule // adc_chip_select_serial_readout_test
